// >>> include/liu_pkg.sv
// Purpose: Shared constants and types of the line interface attenuator
// Assumes: 25 MHz core clock
// Notes: Offsets are byte addresses on the register bus
package liu_pkg;
  localparam int CLK_HZ = 25_000_000;
  // Register byte offsets
  localparam logic [7:0] OFF_TXRX = 8'h00;
  localparam logic [7:0] OFF_MAINT = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  // Field positions and writable masks
  localparam int BIT_DEPTH = 4;
  localparam int BIT_E1 = 5;
  localparam int BIT_RLOOP = 0;
  localparam int BIT_LLOOP = 1;
  localparam int BIT_ALOOP = 2;
  localparam int BIT_TRIP = 3;
  localparam logic [7:0] TXRX_WMASK = 8'h33;
  localparam logic [7:0] MAINT_WMASK = 8'h07;
  localparam logic [7:0] STAT_WMASK = 8'h08;
  localparam logic [7:0] RST_VAL = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // Attenuator geometry and trip limits in unit intervals
  localparam int DEPTH_SHORT = 32;
  localparam int DEPTH_LONG = 128;
  localparam int TRIP_SHORT_UI = 28;
  localparam int TRIP_LONG_UI = 120;
  // Nominal line rates (hertz) and smoothing corners (milli-hertz)
  localparam longint RATE_T1_HZ = 1_544_000;
  localparam longint RATE_E1_HZ = 2_048_000;
  localparam longint CORNER_T1_MHZ = 3750;
  localparam longint CORNER_E1_MHZ = 600;
  localparam longint ADJ_PER_CORNER = 1024;
  // Widened before the product so the cycle count cannot overflow
  localparam int ADJ_T1_CYC = int'(longint'(CLK_HZ) * 1000 / CORNER_T1_MHZ / ADJ_PER_CORNER);
  localparam int ADJ_E1_CYC = int'(longint'(CLK_HZ) * 1000 / CORNER_E1_MHZ / ADJ_PER_CORNER);
  localparam int NCO_W = 24;
  // Trim per bit of fill error; large enough to track a fast line
  localparam int GAIN_SH = 17;
  localparam logic [NCO_W-1:0] STEP_T1 = NCO_W'((RATE_T1_HZ << NCO_W) / CLK_HZ);
  localparam logic [NCO_W-1:0] STEP_E1 = NCO_W'((RATE_E1_HZ << NCO_W) / CLK_HZ);
  // Attenuator path encoding
  typedef enum logic [1:0] {PATH_OFF = 2'b00, PATH_RX = 2'b01, PATH_TX = 2'b10} path_t;
  // Attenuator control states
  typedef enum logic [1:0] {AT_IDLE = 2'b00, AT_FILL = 2'b01, AT_RUN = 2'b10} atst_t;
  // Line and framer pins sampled together
  typedef struct packed {
    logic txClk;
    logic txData;
    logic rxClk;
    logic rxPos;
    logic rxNeg;
  } pins_t;
  // A serial bit with its one-cycle strobe
  typedef struct packed {
    logic dat;
    logic stb;
  } ser_t;
endpackage : liu_pkg

// >>> hw/liu_jitter_atten.sv
// Purpose: Jitter attenuator FIFO, smoothed read clock and line loopbacks
// Assumes: AHB-Lite slave, zero wait states, pins sampled on core_clk
// Notes: Behaviour
// Behaviour
// - FIFO depth 32 or 128 by bit 4
// - Path field selects receive, transmit or off
// - Smoothed clock reads the FIFO out
// - Gapped transmit clock still yields smooth output
// - Latched trip flag beyond 120UI or 28UI
// - Smoothing corner 3.75Hz T1, 0.6Hz E1
// - Analog loop: transmitter feeds receiver, line ignored
// - Local loop: framer data into receive side
// - Remote loop: received data sent on transmit
// - Both loop bits set gives dual loopback
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module liu_jitter_atten
  import liu_pkg::*;
#(
  parameter int ADJ_T1 = ADJ_T1_CYC,
  parameter int ADJ_E1 = ADJ_E1_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic transmitInputClock,
  input wire logic transmitSerialData,
  input wire logic lineRxClock,
  input wire logic lineRxPos,
  input wire logic lineRxNeg,
  output logic lineTxPos,
  output logic lineTxNeg,
  output logic lineTxClock,
  output logic receiveSerialData,
  output logic receiveClock,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge finding
  pins_t pinMeta_r; // First stage, read only by second
  pins_t pinSync_r; // Safe copy
  pins_t pinPrev_r; // For edge detection
  logic txEdge;
  logic rxEdge;
  // Two flops on every pin before any logic looks at it
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
      pinPrev_r <= '0;
    end else begin
      pinMeta_r <= {transmitInputClock, transmitSerialData, lineRxClock, lineRxPos, lineRxNeg};
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
    end
  end
  assign txEdge = pinSync_r.txClk & ~pinPrev_r.txClk;
  assign rxEdge = pinSync_r.rxClk & ~pinPrev_r.rxClk;
  ////////////////////////////////////////////////////////////////////
  // Register bus
  logic [7:0] lineTxrxControlReg_r; // Depth, path, E1 mode
  logic [7:0] lineMaintenanceControlReg_r; // Loopback bits
  logic [7:0] lineLatchedStatusReg_r; // Sticky events
  logic [7:0] irqMask_r; // Same layout as status
  logic [7:0] stat_nxt;
  logic [7:0] wrAddr_r; // Latched write address
  logic wrPend_r; // Write data phase in progress
  logic addrPh;
  logic hit;
  logic rdStat;
  logic wrHit;
  logic tripEv;
  logic [31:0] rdMux;
  assign addrPh = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign hit = (haddr[31:4] == '0) & (haddr[1:0] == 2'h0);
  assign rdStat = addrPh & ~hwrite & hit & (haddr[7:0] == OFF_STAT);
  assign wrHit = wrPend_r & (wrAddr_r == OFF_STAT);
  // Read decode; unmapped words read as zero
  always_comb begin
    rdMux = '0;
    if (!hit) begin
      rdMux = '0;
    end else if (haddr[7:0] == OFF_TXRX) begin
      rdMux[7:0] = lineTxrxControlReg_r;
    end else if (haddr[7:0] == OFF_MAINT) begin
      rdMux[7:0] = lineMaintenanceControlReg_r;
    end else if (haddr[7:0] == OFF_STAT) begin
      rdMux[7:0] = lineLatchedStatusReg_r;
    end else if (haddr[7:0] == OFF_MASK) begin
      rdMux[7:0] = irqMask_r;
    end
  end
  // Address phase capture; always ready, always OKAY
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= RST_VAL;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrPend_r <= addrPh & hwrite & hit;
      wrAddr_r <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addrPh & ~hwrite) begin
        hrdata <= rdMux;
      end
    end
  end
  // Control writes in the data phase; reserved bits stay zero
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      lineTxrxControlReg_r <= RST_VAL;
      lineMaintenanceControlReg_r <= RST_VAL;
      irqMask_r <= RST_VAL;
    end else if (wrPend_r) begin
      if (wrAddr_r == OFF_TXRX) begin
        lineTxrxControlReg_r <= hwdata[7:0] & TXRX_WMASK;
      end else if (wrAddr_r == OFF_MAINT) begin
        lineMaintenanceControlReg_r <= hwdata[7:0] & MAINT_WMASK;
      end else if (wrAddr_r == OFF_MASK) begin
        irqMask_r <= hwdata[7:0] & STAT_WMASK;
      end
    end
  end
  // Sticky status: read or write-one clears, a new event wins
  always_comb begin
    stat_nxt = lineLatchedStatusReg_r;
    if (rdStat) begin
      stat_nxt = '0;
    end else if (wrHit) begin
      stat_nxt = stat_nxt & ~(hwdata[7:0] & STAT_WMASK);
    end
    stat_nxt[BIT_TRIP] = stat_nxt[BIT_TRIP] | tripEv;
  end
  // Status register and level interrupt
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      lineLatchedStatusReg_r <= RST_VAL;
      irq <= 1'b0;
    end else begin
      lineLatchedStatusReg_r <= stat_nxt;
      irq <= |(stat_nxt & irqMask_r);
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Loopback steering
  logic rLoop;
  logic lLoop;
  logic aLoop;
  logic deep;
  path_t path;
  ser_t lineRxIn; // Decoded line receive stream
  ser_t rxIn; // Stream entering receive chain
  ser_t txIn; // Stream entering transmit chain
  ser_t attIn;
  ser_t attOut;
  ser_t rxOut;
  ser_t txOut;
  assign rLoop = lineMaintenanceControlReg_r[BIT_RLOOP];
  assign lLoop = lineMaintenanceControlReg_r[BIT_LLOOP];
  assign aLoop = lineMaintenanceControlReg_r[BIT_ALOOP];
  assign deep = lineTxrxControlReg_r[BIT_DEPTH];
  assign path = path_t'(lineTxrxControlReg_r[1:0]);
  // Source selection for each direction
  always_comb begin
    if (aLoop) begin
      lineRxIn = '{dat: lineTxPos | lineTxNeg, stb: lineTxClock};
    end else begin
      lineRxIn = '{dat: pinSync_r.rxPos | pinSync_r.rxNeg, stb: rxEdge};
    end
    if (lLoop) begin
      rxIn = '{dat: pinSync_r.txData, stb: txEdge};
    end else begin
      rxIn = lineRxIn;
    end
    if (rLoop) begin
      txIn = lineRxIn;
    end else begin
      txIn = '{dat: pinSync_r.txData, stb: txEdge};
    end
    attIn = (path == PATH_TX) ? txIn : rxIn;
    rxOut = (path == PATH_RX) ? attOut : rxIn;
    txOut = (path == PATH_TX) ? attOut : txIn;
  end
  ////////////////////////////////////////////////////////////////////
  // Attenuator FIFO and state
  logic [DEPTH_LONG-1:0] fifo_r;
  logic [6:0] wrPtr_r;
  logic [6:0] rdPtr_r;
  logic [7:0] fill_r;
  atst_t atState_r;
  logic [7:0] cfgPrev_r; // Flush on any change to the txrx control register
  logic atOn;
  logic [6:0] ptrMask;
  logic [7:0] depth;
  logic [7:0] half;
  logic [7:0] limHi;
  logic [7:0] limLo;
  logic ncoCarry;
  logic doWr;
  logic doRd;
  assign atOn = (path == PATH_RX) | (path == PATH_TX);
  assign depth = deep ? 8'(DEPTH_LONG) : 8'(DEPTH_SHORT);
  assign ptrMask = 7'(depth - 8'h01);
  assign half = depth >> 1;
  assign limHi = half + (deep ? 8'(TRIP_LONG_UI / 2) : 8'(TRIP_SHORT_UI / 2));
  assign limLo = half - (deep ? 8'(TRIP_LONG_UI / 2) : 8'(TRIP_SHORT_UI / 2));
  assign doWr = (atState_r != AT_IDLE) & attIn.stb & (fill_r != depth);
  assign doRd = (atState_r == AT_RUN) & ncoCarry & (fill_r != 8'h00);
  // Excursion beyond the window, or an overflow, trips
  assign tripEv = atOn & (atState_r == AT_RUN) & ((fill_r > limHi) | (fill_r < limLo)
                  | (attIn.stb & (fill_r == depth)));
  // Fill to the centre before reading, so both excursions fit
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      atState_r <= AT_IDLE;
      cfgPrev_r <= RST_VAL;
    end else begin
      cfgPrev_r <= lineTxrxControlReg_r;
      case (atState_r)
        AT_IDLE: begin
          if (atOn) begin
            atState_r <= AT_FILL;
          end
        end
        AT_FILL: begin
          if (fill_r >= half) begin
            atState_r <= AT_RUN;
          end
        end
        default: begin
          atState_r <= AT_RUN;
        end
      endcase
      if (!atOn || cfgPrev_r != lineTxrxControlReg_r) begin
        atState_r <= AT_IDLE;
      end
    end
  end
  // Pointers, fill level and storage
  always_ff @(posedge core_clk) begin
    if (!nrst || atState_r == AT_IDLE) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      fill_r <= '0;
      attOut <= '0;
    end else begin
      if (doWr) begin
        fifo_r[wrPtr_r] <= attIn.dat;
        wrPtr_r <= (wrPtr_r + 7'h01) & ptrMask;
      end
      if (doRd) begin
        rdPtr_r <= (rdPtr_r + 7'h01) & ptrMask;
      end
      fill_r <= fill_r + {7'h00, doWr} - {7'h00, doRd};
      attOut <= '{dat: fifo_r[rdPtr_r], stb: doRd};
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Smoothed read clock: phase accumulator trimmed by fill error
  logic [NCO_W-1:0] acc_r;
  logic [NCO_W-1:0] step_r;
  logic [31:0] adjCnt_r;
  logic adjTick;
  logic [8:0] fillErr;
  logic signed [NCO_W+1:0] trim; // Fill error scaled to a step change
  logic signed [NCO_W+1:0] stepSum; // Nominal step plus trim, may go negative
  logic markPol_r; // Polarity of the next line mark
  // Slow trim period sets the smoothing corner for each line standard
  assign adjTick = adjCnt_r >= (lineTxrxControlReg_r[BIT_E1] ? 32'(ADJ_E1) : 32'(ADJ_T1));
  assign fillErr = {1'b0, fill_r} - {1'b0, half};
  assign trim = $signed({{(NCO_W-7){fillErr[8]}}, fillErr}) <<< GAIN_SH;
  assign stepSum = $signed({2'b00, (lineTxrxControlReg_r[BIT_E1] ? STEP_E1 : STEP_T1)}) + trim;
  // The input clock never drives reads; gaps only move the fill level
  always_ff @(posedge core_clk) begin
    if (!nrst || !atOn) begin
      acc_r <= '0;
      step_r <= STEP_T1;
      adjCnt_r <= '0;
      ncoCarry <= 1'b0;
    end else begin
      {ncoCarry, acc_r} <= {1'b0, acc_r} + {1'b0, step_r};
      if (adjTick) begin
        step_r <= stepSum[NCO_W+1] ? '0 : stepSum[NCO_W-1:0];
        adjCnt_r <= '0;
      end else begin
        adjCnt_r <= adjCnt_r + 32'h1;
      end
    end
  end
  // Line encoder alternates mark polarity; receive side hands bits to the framer
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      lineTxPos <= 1'b0;
      lineTxNeg <= 1'b0;
      lineTxClock <= 1'b0;
      markPol_r <= 1'b0;
      receiveSerialData <= 1'b0;
      receiveClock <= 1'b0;
    end else begin
      lineTxClock <= txOut.stb;
      receiveClock <= rxOut.stb;
      if (txOut.stb) begin
        lineTxPos <= txOut.dat & ~markPol_r;
        lineTxNeg <= txOut.dat & markPol_r;
        markPol_r <= markPol_r ^ txOut.dat;
      end
      if (rxOut.stb) begin
        receiveSerialData <= rxOut.dat;
      end
    end
  end
  default clocking atCb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence txMarked; lineTxClock && ((lineTxPos | lineTxNeg) == $past(txOut.dat)); endsequence
  sequence rxMarked; receiveClock && (receiveSerialData == $past(rxOut.dat)); endsequence
  sequence filled; atState_r == AT_FILL && fill_r >= half && atOn; endsequence
  sequence cfgSame; cfgPrev_r == lineTxrxControlReg_r; endsequence
  tx_line_a: assert property (txOut.stb |=> txMarked) else $error("tx line bit lost");
  rx_out_a: assert property (rxOut.stb |=> rxMarked) else $error("rx bit lost");
  fill_run_a: assert property (filled ##0 cfgSame |=> atState_r == AT_RUN)
    else $error("stuck in fill");
  trip_latch_a: assert property (tripEv |=> lineLatchedStatusReg_r[BIT_TRIP])
    else $error("trip not latched");
  trip_off_a: assert property (!atOn |-> !tripEv) else $error("trip while off");
  path_off_a: assert property (!atOn |=> atState_r == AT_IDLE) else $error("not idle");
endmodule : liu_jitter_atten

// >>> test/liu_line_model.sv
// Purpose: Line and framer side model for the attenuator block
// Assumes: Link bit period of 320 ns, gapped bursts on request
// Notes: Idle receive lines toggle so no stale level is held
`timescale 1ns/1ps
module liu_line_model (
  input wire logic run,
  input wire logic burst,
  input wire logic rxBit,
  input wire logic txBit,
  output logic txClk,
  output logic txData,
  output logic rxClk,
  output logic rxPos,
  output logic rxNeg
);
  logic markPol; // Alternates on each mark
  initial begin
    txClk = 1'b0;
    rxClk = 1'b0;
    txData = 1'b0;
    rxPos = 1'b0;
    rxNeg = 1'b0;
    markPol = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Receive clock runs only within a frame
  always begin
    #160;
    if (run) begin
      rxClk = ~rxClk;
    end else begin
      rxClk = 1'b0;
      rxPos = ~rxPos;
      rxNeg = ~rxNeg;
    end
  end
  // Dual rail marks, alternating polarity
  always @(negedge rxClk) begin
    if (run) begin
      rxPos <= rxBit & ~markPol;
      rxNeg <= rxBit & markPol;
      markPol <= markPol ^ rxBit;
    end
  end
  // Framer clock: steady, or fast bursts then a long gap
  always begin
    if (run && burst) begin
      repeat (160) begin
        #80 txClk = ~txClk;
      end
      #40000;
    end else if (run) begin
      #160 txClk = ~txClk;
    end else begin
      #160;
    end
  end
  // Framer data changes on the falling edge
  always @(negedge txClk) begin
    txData <= txBit;
  end
endmodule : liu_line_model

// >>> test/liu_jitter_atten_tb_top.sv
// Purpose: Self-checking bench for the attenuator and loopbacks
// Assumes: Zero or more wait states on the register bus
// Notes: Loop paths are judged by the level that finally appears
`timescale 1ns/1ps
module liu_jitter_atten_tb_top;
  import liu_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq, lineTxPos, lineTxNeg, receiveSerialData;
  logic [31:0] hrdata;
  logic txClk, txData, rxClk, rxPos, rxNeg;
  logic run = 1'b0;
  logic burst = 1'b0;
  logic rxBit = 1'b0;
  logic txBit = 1'b0;
  logic [31:0] rd; // Last read data
  logic [2:0] obs; // Watched outputs
  int errors = 0;
  int nChecks = 0;
  assign obs = {irq, lineTxPos | lineTxNeg, receiveSerialData};
  always #20 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////
  liu_jitter_atten #(.ADJ_T1(4), .ADJ_E1(4)) liu_jitter_atten_i (
    .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .transmitInputClock(txClk), .transmitSerialData(txData),
    .lineRxClock(rxClk), .lineRxPos(rxPos), .lineRxNeg(rxNeg),
    .lineTxPos(lineTxPos), .lineTxNeg(lineTxNeg), .lineTxClock(),
    .receiveSerialData(receiveSerialData), .receiveClock(), .irq(irq));
  liu_line_model liu_line_model_i (.run(run), .burst(burst), .rxBit(rxBit),
    .txBit(txBit), .txClk(txClk), .txData(txData), .rxClk(rxClk),
    .rxPos(rxPos), .rxNeg(rxNeg));
  ////////////////////////////////////////////////////////////////
  task automatic finalReport;
    $display("checks %0d mismatches %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finalReport
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One single transfer; waits for ready under a bound
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
    if (n >= 100) begin
      errors++;
      finalReport();
    end
  endtask : bus
  // Waits a bounded time for a watched output level
  task automatic waitObs(input int b, input logic v, input string nm);
    int n;
    n = 0;
    while (obs[b] !== v && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    chk(nm, {31'h0, obs[b]}, {31'h0, v});
    if (n == 4000) begin
      finalReport();
    end
  endtask : waitObs
  // Sets the mode, drives a level, then flips both sources
  task automatic loopCase(input string nm, input logic [7:0] tr, input logic [7:0] mt,
                          input logic r, input logic t, input int b);
    bus(1'b1, OFF_TXRX, {24'h0, tr});
    bus(1'b1, OFF_MAINT, {24'h0, mt});
    rxBit <= r;
    txBit <= t;
    waitObs(b, 1'b1, nm);
    rxBit <= ~r;
    txBit <= ~t;
    waitObs(b, 1'b0, nm);
    $display("%s done", nm);
  endtask : loopCase
  ////////////////////////////////////////////////////////////////
  task automatic tRegs;
    logic [7:0] offs [4];
    offs = '{OFF_TXRX, OFF_MAINT, OFF_STAT, OFF_MASK};
    foreach (offs[i]) begin
      bus(1'b0, offs[i], 32'h0);
      chk("reset value", rd, 32'h0);
    end
    bus(1'b1, OFF_TXRX, 32'hFF);
    bus(1'b0, OFF_TXRX, 32'h0);
    chk("txrx", rd, {24'h0, TXRX_WMASK});
    bus(1'b1, OFF_MAINT, 32'hFF);
    bus(1'b0, OFF_MAINT, 32'h0);
    chk("maint", rd, {24'h0, MAINT_WMASK});
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("regs done");
  endtask : tRegs
  task automatic tTrip;
    bus(1'b1, OFF_TXRX, 32'h02);
    bus(1'b1, OFF_MAINT, 32'h0);
    bus(1'b0, OFF_STAT, 32'h0);
    bus(1'b1, OFF_MASK, 32'h08);
    burst <= 1'b1;
    waitObs(2, 1'b1, "irq");
    burst <= 1'b0;
    repeat (2000) @(posedge core_clk);
    bus(1'b0, OFF_STAT, 32'h0);
    chk("trip", rd, 32'h08);
    bus(1'b1, OFF_STAT, 32'h08);
    waitObs(2, 1'b0, "irq clear");
    bus(1'b1, OFF_TXRX, 32'h0);
    bus(1'b0, OFF_STAT, 32'h0);
    burst <= 1'b1;
    repeat (1500) @(posedge core_clk);
    burst <= 1'b0;
    bus(1'b0, OFF_STAT, 32'h0);
    chk("trip off", rd, 32'h0);
    $display("trip done");
  endtask : tTrip
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    run <= 1'b1;
    @(posedge core_clk);
    tRegs();
    loopCase("bypass", 8'h00, 8'h00, 1'b1, 1'b0, 0);
    loopCase("remote", 8'h11, 8'h01, 1'b1, 1'b0, 1);
    loopCase("local", 8'h00, 8'h02, 1'b0, 1'b1, 0);
    loopCase("dual tx", 8'h01, 8'h03, 1'b1, 1'b0, 1);
    loopCase("dual rx", 8'h01, 8'h03, 1'b0, 1'b1, 0);
    loopCase("analog", 8'h20, 8'h04, 1'b0, 1'b1, 0);
    tTrip();
    finalReport();
  end
endmodule : liu_jitter_atten_tb_top
